/* File: rtl/mis_pkg.sv */
package mis_pkg;
	// ****************************************************
	// Register addresses on the microprocessor port
	// ****************************************************
	localparam logic [6:0] ADDR_RESET = 7'h00; // Software reset word
	localparam logic [6:0] ADDR_CONFIG = 7'h01; // Configuration word
	localparam logic [6:0] ADDR_STAT1 = 7'h02; // First status register
	localparam logic [6:0] ADDR_STAT2 = 7'h03; // Second status register
	localparam logic [6:0] ADDR_EN1 = 7'h04; // First enable register
	localparam logic [6:0] ADDR_EN2 = 7'h05; // Second enable register
	localparam logic [6:0] ADDR_ALARM = 7'h07; // Alarmed connection index
	// ****************************************************
	// Field positions and reset values
	// ****************************************************
	localparam int SOFT_RESET_BIT = 15; // Software reset bit
	localparam int CFG_BUSY_POL = 9; // Busy polarity select
	localparam int CFG_DMA_REQUEST_OUT_INV = 8; // DMA request invert
	localparam int CFG_XPOL_LOG = 7; // Excess violation log enable
	localparam int CFG_RDI_LOG = 6; // Remote defect log enable
	localparam int CFG_AIS_LOG = 5; // Alarm signal log enable
	localparam int CFG_POL_LOG = 4; // Violation log enable
	localparam int CFG_CC_LOG = 3; // Continuity log enable
	localparam logic [15:0] CFG_RESET = 16'h0001; // Standby set
	localparam logic [15:0] CFG_MASK = 16'h03ff; // Writable bits
	localparam int S1_SUMMARY = 15; // Second register summary
	localparam int S1_COUNTER_MOVED = 14; // Counter transfer
	localparam int S1_INSRDY = 13; // Insert ready
	localparam int S1_EXTAVL = 12; // Extract available
	localparam int S1_EXTOVR = 11; // Extract overrun
	localparam int S1_QVALID = 10; // Alarm queue non-empty
	localparam int S1_FULL = 9; // Output buffer full
	localparam int S1_PCELL = 8; // Physical layer cell
	localparam int S1_XPOL = 7; // Excess violation
	localparam int S1_RDI = 6; // Remote defect change
	localparam int S1_AIS = 5; // Alarm signal change
	localparam int S1_POL = 4; // Contract violation
	localparam int S1_CC = 3; // Continuity change
	localparam int S1_OAM = 2; // Maintenance cell error
	localparam int S1_HDR = 1; // Header field error
	localparam int S1_UNMATCH = 0; // Unmatched cell
	localparam int S2_SRCH = 9; // Search error
	localparam int S2_SPAR = 4; // SRAM parity, five bits up
	localparam int S2_IPAR = 2; // Input parity, two bits up
	localparam int S2_SOC = 1; // Start-of-cell error
	localparam logic [15:0] EN1_MASK = 16'h7bff; // Writable enables
	localparam logic [15:0] EN2_MASK = 16'h03fe; // Writable enables
	localparam logic [15:0] S1_STORE = 16'h7bff; // Sticky bits only
	// ****************************************************
	// Cell field values and counts
	// ****************************************************
	localparam logic [2:0] OUT_FULL_CELLS = 3'h4; // Buffer capacity
	localparam logic [4:0] CELL_LAST = 5'h1a; // Last word index
	localparam logic [15:0] VCI_BAD_LOW = 16'h0007; // Reserved VCI low
	localparam logic [15:0] VCI_BAD_HIGH = 16'h000f; // Reserved VCI high
	localparam logic [15:0] VCI_VP_RM = 16'h0006; // VP resource mgmt
	localparam logic [2:0] PTI_VCC_BAD = 3'h7; // Illegal VCC PTI
	localparam logic [2:0] PTI_RM = 3'h6; // Resource mgmt PTI
endpackage

/* File: rtl/mis_top.sv */
`timescale 1ns/10ps
// Behaviour
// - RDI change logs index when enabled
// - DMA request polarity follows invert bit
// - Busy polarity follows select bit
// - Reading status one clears event bits
// - Search miss or bad RM CRC flags
// - Bad PTI or VCI sets header flag
// - OAM errors flag; option limits to CRC
// - Continuity alarm change sets flag
// - Traffic contract violation sets flag
// - AIS entry or exit sets flag
// - RDI entry or exit sets flag
// - Count MSB set cell flags excess
// - Enabled alarm logs index at the next edge, with its flag
// - Zero VCI with CLP one flags
// - Queue valid bit live, mirrored, not stored
// - Buffer full or FIFO reset flags
// - Extract overrun sets flag
// - Extract cell ready sets flag
// - Insert buffer empty sets flag
// - Counter transfer or overrun sets flag
// - Summary bit tracks second register live
// - Misplaced cell start flags, sets address to one
// - Enabled status drives interrupt low
// - Reading status two clears parity bits
module mis_top
	import mis_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [6:0] up_addr,
	input wire logic up_rd,
	input wire logic up_wr,
	input wire logic [15:0] up_wdata,
	output logic [15:0] up_rdata,
	output logic alarm_index_pop,
	input wire logic search_miss,
	input wire logic bad_routing,
	input wire logic rm_crc_bad,
	input wire logic hdr_valid,
	input wire logic hdr_vpc,
	input wire logic [2:0] hdr_pti,
	input wire logic [15:0] hdr_vci,
	input wire logic hdr_clp,
	input wire logic oam_cell,
	input wire logic oam_type_bad,
	input wire logic oam_func_bad,
	input wire logic oam_crc_bad,
	input wire logic count_undefined_option,
	input wire logic [15:0] conn_index,
	input wire logic cc_change,
	input wire logic violation,
	input wire logic ais_change,
	input wire logic rdi_change,
	input wire logic excess_hit,
	input wire logic alarm_queue_nonempty,
	input wire logic [2:0] out_buffer_level,
	input wire logic output_fifo_reset,
	input wire logic extract_overrun,
	input wire logic extract_cell_ready,
	input wire logic insert_empty,
	input wire logic counter_moved,
	input wire logic counter_overrun,
	input wire logic [4:0] sram_parity_error_flags,
	input wire logic [1:0] input_parity_error_flags,
	input wire logic search_error,
	input wire logic input_cell_start,
	input wire logic input_word_strobe,
	output logic [4:0] write_address,
	input wire logic dma_request_in,
	input wire logic busy_in,
	output logic dma_request_out,
	output logic busy_out,
	output logic interrupt_out_n
);
	// ****************************************************
	// State
	// ****************************************************
	logic soft_reset; // Software reset bit
	logic [15:0] config_word; // Configuration word
	logic [15:0] enable_one; // First enable register
	logic [15:0] enable_two; // Second enable register
	logic [15:0] status_one; // Sticky first status bits
	logic [15:0] status_two; // Sticky second status bits
	logic [15:0] alarm_index; // Latest alarmed connection
	logic [4:0] word_count; // Write address counter
	logic soc_meta; // Cell start sync stage one
	logic soc_sync; // Cell start sync stage two
	logic ready_d; // Extract ready, last cycle
	logic empty_d; // Insert empty, last cycle
	logic moved_d; // Counter flags, last cycle
	logic next_soft_reset;
	logic [15:0] next_config_word;
	logic [15:0] next_enable_one;
	logic [15:0] next_enable_two;
	logic [15:0] next_status_one;
	logic [15:0] next_status_two;
	logic [15:0] next_alarm_index;
	logic [4:0] next_word_count;
	logic [15:0] next_up_rdata;
	logic next_pop;
	logic next_int_n;
	logic [15:0] event_one; // Events seen this cycle
	logic [15:0] event_two; // Events seen this cycle
	logic [15:0] view_one; // First status as read
	logic block_reset; // Hardware or software reset
	logic rd_one; // Read of first status
	logic rd_two; // Read of second status

	// True when VCI lies in an inclusive range
	function automatic logic vci_in(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		vci_in = (v >= lo) && (v <= hi);
	endfunction

	// ****************************************************
	// Event decode
	// ****************************************************
	// Collect this cycle's events into register layout
	always_comb
	begin
		event_one = 16'h0000;
		event_one[S1_UNMATCH] = search_miss | bad_routing | rm_crc_bad;
		event_one[S1_HDR] = hdr_valid &
			((!hdr_vpc && hdr_pti == PTI_VCC_BAD) ||
			(hdr_vpc && vci_in(hdr_vci, VCI_BAD_LOW, VCI_BAD_HIGH)) ||
			(hdr_vpc && hdr_vci == VCI_VP_RM && hdr_pti != PTI_RM));
		event_one[S1_OAM] = oam_cell & (oam_crc_bad |
			(~count_undefined_option & (oam_type_bad | oam_func_bad)));
		event_one[S1_CC] = cc_change;
		event_one[S1_POL] = violation;
		event_one[S1_AIS] = ais_change;
		event_one[S1_RDI] = rdi_change;
		event_one[S1_XPOL] = excess_hit;
		event_one[S1_PCELL] = hdr_valid & hdr_clp &
			(hdr_vci == 16'h0000);
		event_one[S1_FULL] = (out_buffer_level >= OUT_FULL_CELLS) |
			output_fifo_reset;
		event_one[S1_EXTOVR] = extract_overrun;
		event_one[S1_EXTAVL] = extract_cell_ready & ~ready_d;
		event_one[S1_INSRDY] = insert_empty & ~empty_d;
		event_one[S1_COUNTER_MOVED] = (counter_moved | counter_overrun) &
			~moved_d;
		event_two = 16'h0000;
		event_two[S2_SRCH] = search_error;
		event_two[S2_SPAR +: 5] = sram_parity_error_flags;
		event_two[S2_IPAR +: 2] = input_parity_error_flags;
		event_two[S2_SOC] = soc_sync & input_word_strobe &
			(word_count != 5'h00);
	end

	// ****************************************************
	// Status, configuration and register port
	// ****************************************************
	// First status with its live bits filled in
	always_comb
	begin
		view_one = status_one;
		view_one[S1_SUMMARY] = |status_two;
		view_one[S1_QVALID] = alarm_queue_nonempty;
	end

	assign block_reset = rst | soft_reset;
	assign rd_one = up_rd && (up_addr == ADDR_STAT1);
	assign rd_two = up_rd && (up_addr == ADDR_STAT2);

	// Next values of registers and outputs
	always_comb
	begin
		next_soft_reset = soft_reset;
		next_config_word = config_word;
		next_enable_one = enable_one;
		next_enable_two = enable_two;
		next_alarm_index = alarm_index;
		next_up_rdata = 16'h0000;
		next_pop = 1'b0;
		// Writes from the microprocessor
		if (up_wr)
		begin
			case (up_addr)
				ADDR_RESET: next_soft_reset = up_wdata[SOFT_RESET_BIT];
				ADDR_CONFIG: next_config_word = up_wdata & CFG_MASK;
				ADDR_EN1: next_enable_one = up_wdata & EN1_MASK;
				ADDR_EN2: next_enable_two = up_wdata & EN2_MASK;
				default: next_soft_reset = soft_reset;
			endcase
		end
		// Read data, sampled before any clear
		if (up_rd)
		begin
			case (up_addr)
				ADDR_RESET: next_up_rdata = {soft_reset, 15'h0000};
				ADDR_CONFIG: next_up_rdata = config_word;
				ADDR_STAT1: next_up_rdata = view_one;
				ADDR_STAT2: next_up_rdata = status_two;
				ADDR_EN1: next_up_rdata = enable_one |
					{5'h00, alarm_queue_nonempty, 10'h000};
				ADDR_EN2: next_up_rdata = enable_two;
				ADDR_ALARM:
				begin
					next_up_rdata = alarm_index;
					next_pop = 1'b1;
				end
				default: next_up_rdata = 16'h0000;
			endcase
		end
		// Sticky bits; a new event beats the clearing read
		next_status_one = ((rd_one ? 16'h0000 : status_one) |
			event_one) & S1_STORE;
		next_status_two = (rd_two ? 16'h0000 : status_two) |
			event_two;
		// Log the connection of any enabled alarm
		if ((cc_change && config_word[CFG_CC_LOG]) ||
			(violation && config_word[CFG_POL_LOG]) ||
			(ais_change && config_word[CFG_AIS_LOG]) ||
			(rdi_change && config_word[CFG_RDI_LOG]) ||
			(excess_hit && config_word[CFG_XPOL_LOG]))
		begin
			next_alarm_index = conn_index;
		end
		// Any enabled status bit pulls the interrupt low
		next_int_n = ~(|(next_status_one & enable_one) |
			|(next_status_two & enable_two));
	end

	// Registers owned by hardware reset only
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			soft_reset <= 1'b0;
			config_word <= CFG_RESET;
			enable_one <= 16'h0000;
			enable_two <= 16'h0000;
			up_rdata <= 16'h0000;
			alarm_index_pop <= 1'b0;
		end
		else
		begin
			soft_reset <= next_soft_reset;
			config_word <= next_config_word;
			enable_one <= next_enable_one;
			enable_two <= next_enable_two;
			up_rdata <= next_up_rdata;
			alarm_index_pop <= next_pop;
		end
	end

	// Event state, also cleared by software reset
	always_ff @(posedge sys_clk)
	begin
		if (block_reset)
		begin
			status_one <= 16'h0000;
			status_two <= 16'h0000;
			alarm_index <= 16'h0000;
			interrupt_out_n <= 1'b1;
			ready_d <= 1'b0;
			empty_d <= 1'b0;
			moved_d <= 1'b0;
		end
		else
		begin
			status_one <= next_status_one;
			status_two <= next_status_two;
			alarm_index <= next_alarm_index;
			interrupt_out_n <= next_int_n;
			ready_d <= extract_cell_ready;
			empty_d <= insert_empty;
			moved_d <= counter_moved | counter_overrun;
		end
	end

	// ****************************************************
	// Input cell word counter
	// ****************************************************
	// Cell start realigns the counter to the first word
	always_comb
	begin
		next_word_count = word_count;
		if (input_word_strobe)
		begin
			if (soc_sync)
				next_word_count = 5'h01;
			else if (word_count == CELL_LAST)
				next_word_count = 5'h00;
			else
				next_word_count = word_count + 5'h01;
		end
	end

	// Counter, start synchroniser and polarity outputs
	always_ff @(posedge sys_clk)
	begin
		if (block_reset)
		begin
			word_count <= 5'h00;
			soc_meta <= 1'b0;
			soc_sync <= 1'b0;
			dma_request_out <= 1'b0;
			busy_out <= 1'b1;
		end
		else
		begin
			word_count <= next_word_count;
			soc_meta <= input_cell_start;
			soc_sync <= soc_meta;
			dma_request_out <= dma_request_in ^
				config_word[CFG_DMA_REQUEST_OUT_INV];
			busy_out <= busy_in ~^ config_word[CFG_BUSY_POL];
		end
	end

	assign write_address = word_count;

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (block_reset);

	unmatch_set_a: assert property (search_miss |=>
		status_one[S1_UNMATCH]) else $error("unmatched flag not set");
	hdr_flag_a: assert property (hdr_valid && !hdr_vpc &&
		hdr_pti == PTI_VCC_BAD |=> status_one[S1_HDR])
		else $error("header flag not set");
	oam_option_a: assert property ($rose(status_one[S1_OAM]) |->
		$past(oam_cell & (oam_crc_bad | (~count_undefined_option &
		(oam_type_bad | oam_func_bad))))) else $error("bad oam set");
	rdi_log_a: assert property (rdi_change &&
		config_word[CFG_RDI_LOG] |=> alarm_index == $past(conn_index))
		else $error("rdi index not logged");
	cc_log_a: assert property (cc_change && config_word[CFG_CC_LOG]
		|=> status_one[S1_CC] && alarm_index == $past(conn_index))
		else $error("cc index not logged");
	dma_pol_a: assert property (!block_reset |=> dma_request_out ==
		$past(dma_request_in ^ config_word[CFG_DMA_REQUEST_OUT_INV]))
		else $error("dma polarity wrong");
	busy_pol_a: assert property (config_word[CFG_BUSY_POL] &&
		$stable(config_word) && busy_in |=> busy_out)
		else $error("busy polarity wrong");
	read_clear_a: assert property (rd_one && event_one == 16'h0000
		|=> (status_one & S1_STORE) == 16'h0000)
		else $error("status one not cleared");
	set_wins_a: assert property (rd_one && violation |=>
		status_one[S1_POL]) else $error("event lost on read");
	summary_bit_a: assert property (rd_one |=>
		up_rdata[S1_SUMMARY] == $past(|status_two))
		else $error("summary bit wrong");
	queue_copy_a: assert property (up_rd && up_addr == ADDR_EN1
		|=> up_rdata[S1_QVALID] == $past(alarm_queue_nonempty))
		else $error("queue copy wrong");
	soc_error_a: assert property (soc_sync && input_word_strobe &&
		word_count != 5'h00 |=> status_two[S2_SOC] &&
		write_address == 5'h01) else $error("cell start mishandled");
	parity_clear_a: assert property (rd_two && event_two ==
		16'h0000 |=> status_two == 16'h0000)
		else $error("status two not cleared");
	irq_drive_a: assert property (|(status_one & enable_one)
		&& !rd_one && $stable(status_one) && $stable(enable_one) |=>
		!interrupt_out_n) else $error("interrupt not driven");
	full_flag_a: assert property (output_fifo_reset |=>
		status_one[S1_FULL]) else $error("full flag not set");

	irq_seen_c: cover property (!interrupt_out_n ##1 rd_one);
	log_seen_c: cover property (excess_hit && config_word[CFG_XPOL_LOG]);
	soc_seen_c: cover property (event_two[S2_SOC]);
endmodule // mis_top

/* File: sim/mis_top_tb.sv */
`timescale 1ns/10ps
module mis_top_tb;
	import mis_pkg::*;
	// ****
	// Design signals
	// ****
	logic sys_clk, rst, up_rd, up_wr, alarm_index_pop;
	logic [6:0] up_addr;
	logic [15:0] up_wdata, up_rdata, hdr_vci, conn_index;
	logic search_miss, bad_routing, rm_crc_bad, hdr_valid, hdr_vpc, hdr_clp;
	logic [2:0] hdr_pti, out_buffer_level;
	logic oam_cell, oam_type_bad, oam_func_bad, oam_crc_bad;
	logic count_undefined_option, cc_change, violation, ais_change;
	logic rdi_change, excess_hit, alarm_queue_nonempty, output_fifo_reset;
	logic extract_overrun, extract_cell_ready, insert_empty, counter_moved;
	logic counter_overrun, search_error, input_cell_start, input_word_strobe;
	logic [4:0] sram_parity_error_flags, write_address;
	logic [1:0] input_parity_error_flags;
	logic dma_request_in, busy_in, dma_request_out, busy_out, interrupt_out_n;
	int mismatches, checks_done, cycles;
	logic rd_taken; // Read accepted last edge
	logic pop_want; // Alarm pop expected this cycle
	logic [15:0] want_two; // Expected second status
	logic [31:0] exp_q[$]; // Mask and expected read data
	logic [31:0] note; // Oldest note
	logic [15:0] idx; // Random connection index
	int bits[22] = '{0,0,0,1,1,1,2,2,2,3,4,5,6,7,8,9,9,11,12,13,14,14};
	mis_top dut (.*);
	// ****
	// Clock, checks and helpers
	// ****
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Read data compared once settled
	always @(posedge sys_clk)
	begin
		rd_taken <= up_rd;
		pop_want <= up_rd && (up_addr == ADDR_ALARM);
	end
	always @(negedge sys_clk)
	begin
		if (rd_taken === 1'b1)
		begin
			note = exp_q.pop_front();
			checks_done++;
			if ((up_rdata & note[31:16]) !== (note[15:0] & note[31:16]))
			begin
				mismatches++;
				$display("BAD %0t read %h want %h", $time, up_rdata, note[15:0]);
			end
		end
		// Alarm index pop follows each read of the index
		if (alarm_index_pop !== pop_want)
		begin
			mismatches++;
			$display("BAD %0t pop %b want %b", $time, alarm_index_pop, pop_want);
		end
	end
	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			finish_test();
		end
	end
	task automatic tick(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(logic got, logic want);
		checks_done++;
		if (got !== want)
		begin
			mismatches++;
			$display("BAD %0t pin %b want %b", $time, got, want);
		end
	endtask
	task automatic rd(logic [6:0] a, logic [15:0] e, logic [15:0] m = 16'hffff);
		up_addr = a;
		up_rd = 1'b1;
		exp_q.push_back({m, e});
		tick(1);
		up_rd = 1'b0;
		tick(1);
	endtask
	task automatic wr(logic [6:0] a, logic [15:0] d);
		up_addr = a;
		up_wdata = d;
		up_wr = 1'b1;
		tick(1);
		up_wr = 1'b0;
		tick(1);
	endtask
	// Quiet values on every event input that fire drives
	task automatic idle();
		{search_miss, bad_routing, rm_crc_bad, hdr_valid, hdr_vpc} = '0;
		{oam_cell, oam_type_bad, oam_func_bad, oam_crc_bad, hdr_clp} = '0;
		{cc_change, violation, ais_change, rdi_change, excess_hit} = '0;
		{output_fifo_reset, extract_overrun, extract_cell_ready} = '0;
		{insert_empty, counter_moved, counter_overrun, search_error} = '0;
		{sram_parity_error_flags, input_parity_error_flags} = '0;
		hdr_pti = 3'h0;
		hdr_vci = 16'h0020;
		out_buffer_level = 3'h0;
	endtask
	// One event of kind k for one cycle
	task automatic fire(int k);
		idx = 16'($urandom());
		conn_index = idx;
		case (k)
			0: search_miss = 1'b1;
			1: bad_routing = 1'b1;
			2: rm_crc_bad = 1'b1;
			3: {hdr_valid, hdr_pti} = {1'b1, PTI_VCC_BAD};
			4: {hdr_valid, hdr_vpc, hdr_vci} = {2'b11, 16'(7 + $urandom % 9)};
			5: {hdr_valid, hdr_vpc, hdr_vci, hdr_pti} = {2'b11, VCI_VP_RM, 3'h2};
			6: {oam_cell, oam_type_bad} = 2'b11;
			7: {oam_cell, oam_func_bad} = 2'b11;
			8: {oam_cell, oam_crc_bad} = 2'b11;
			9: cc_change = 1'b1;
			10: violation = 1'b1;
			11: ais_change = 1'b1;
			12: rdi_change = 1'b1;
			13: excess_hit = 1'b1;
			14: {hdr_valid, hdr_vci, hdr_clp} = {1'b1, 16'h0000, 1'b1};
			15: out_buffer_level = OUT_FULL_CELLS;
			16: output_fifo_reset = 1'b1;
			17: extract_overrun = 1'b1;
			18: extract_cell_ready = 1'b1;
			19: insert_empty = 1'b1;
			20: counter_moved = 1'b1;
			default: counter_overrun = 1'b1;
		endcase
		tick(1);
		idle();
		tick(1);
	endtask
	task automatic finish_test();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ****
	// Main sequence
	// ****
	initial
	begin
		void'($urandom(32'h42dba903));
		{rst, up_rd, up_wr, up_addr, up_wdata, conn_index} = '0;
		{count_undefined_option, alarm_queue_nonempty, input_cell_start} = '0;
		{input_word_strobe, dma_request_in, busy_in} = '0;
		idle();
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		chk(interrupt_out_n, 1'b1);
		rd(ADDR_CONFIG, CFG_RESET);
		rd(ADDR_STAT1, 16'h0000);
		rd(7'h06, 16'h0000);
		wr(ADDR_CONFIG, 16'h00f8);
		for (int k = 0; k < 22; k++)
		begin
			fire(k);
			if (k >= 9 && k <= 13)
				rd(ADDR_ALARM, idx);
			if (k < 9)
				rd(ADDR_STAT1, 16'(1 << bits[k]));
			else if (k < 16)
				rd(ADDR_STAT1, 16'(1 << bits[k]));
			else
				rd(ADDR_STAT1, 16'(1 << bits[k]));
			rd(ADDR_STAT1, 16'h0000);
		end
		count_undefined_option = 1'b1;
		fire(6);
		fire(7);
		rd(ADDR_STAT1, 16'h0000);
		fire(8);
		rd(ADDR_STAT1, 16'h0004);
		wr(ADDR_STAT1, 16'hffff);
		rd(ADDR_STAT1, 16'h0000);
		// Event lands in the clearing read cycle
		violation = 1'b1;
		up_addr = ADDR_STAT1;
		up_rd = 1'b1;
		exp_q.push_back(32'hffff0000);
		tick(1);
		{violation, up_rd} = 2'b00;
		tick(1);
		rd(ADDR_STAT1, 16'h0010);
		alarm_queue_nonempty = 1'b1;
		wr(ADDR_EN1, 16'h0010);
		rd(ADDR_STAT1, 16'h0400);
		rd(ADDR_STAT1, 16'h0400);
		rd(ADDR_EN1, 16'h0410);
		alarm_queue_nonempty = 1'b0;
		tick(2);
		rd(ADDR_STAT1, 16'h0000);
		fire(10);
		chk(interrupt_out_n, 1'b0);
		rd(ADDR_STAT1, 16'h0010);
		chk(interrupt_out_n, 1'b1);
		wr(ADDR_EN1, 16'h0000);
		fire(10);
		chk(interrupt_out_n, 1'b1);
		rd(ADDR_STAT1, 16'h0010);
		sram_parity_error_flags = 5'($urandom | 1);
		input_parity_error_flags = 2'b11;
		search_error = 1'b1;
		want_two = {6'h0, 1'b1, sram_parity_error_flags, 4'hc};
		tick(1);
		idle();
		tick(1);
		rd(ADDR_STAT1, 16'h8000);
		rd(ADDR_STAT1, 16'h8000);
		rd(ADDR_STAT2, want_two);
		rd(ADDR_STAT2, 16'h0000);
		rd(ADDR_STAT1, 16'h0000);
		wr(ADDR_EN2, 16'h0002);
		input_word_strobe = 1'b1;
		tick(5);
		input_word_strobe = 1'b0;
		input_cell_start = 1'b1;
		tick(4);
		input_word_strobe = 1'b1;
		tick(1);
		{input_word_strobe, input_cell_start} = 2'b00;
		tick(3);
		chk(write_address === 5'h01, 1'b1);
		chk(interrupt_out_n, 1'b0);
		rd(ADDR_STAT2, 16'h0002);
		{dma_request_in, busy_in} = 2'b11;
		wr(ADDR_CONFIG, 16'h0000);
		tick(2);
		chk(dma_request_out, 1'b1);
		chk(busy_out, 1'b0);
		wr(ADDR_CONFIG, 16'h0300);
		tick(2);
		chk(dma_request_out, 1'b0);
		chk(busy_out, 1'b1);
		rd(ADDR_CONFIG, 16'h0300);
		wr(ADDR_CONFIG, 16'h0000);
		wr(ADDR_EN1, 16'h0040);
		fire(12);
		chk(interrupt_out_n, 1'b0);
		wr(ADDR_RESET, 16'h8000);
		tick(2);
		chk(interrupt_out_n, 1'b1);
		chk(dma_request_out, 1'b0);
		rd(ADDR_STAT1, 16'h0000);
		wr(ADDR_RESET, 16'h0000);
		rd(ADDR_STAT1, 16'h0000);
		tick(3);
		finish_test();
	end
endmodule // mis_top_tb
